// >>> obc_top.sv
// boost enable, per-processor disengage and energy bias hint registers
// assumes model-specific register accesses on clk_sys, one per cycle
// Operation
// - reset value of disable bit reports support
// - one disable bit for whole package
// - write 1 disables boost, 0 enables
// - query bit clear whenever boost disabled
// - control bit 32 disengages boost per processor
// - status register never shows disengage bit
// - separate disengage bit per logical processor
// - boost only when enabled, headroom, criteria
// - actual over reference counter exceeds one
// - query reports bias register present
// - four-bit bias field, values 0 to 15
// - bias resets to highest performance
// - independent bias per logical processor
// - shared level takes most performance-oriented hint
// - bias is only a guidance hint
`timescale 1ns/1ps
`include "obc_params.svh"
module obc_top import obc_pkg::*; (
    input wire logic clk_sys, // 50 MHz core clock
    input wire logic resetn, // async reset, active low
    input wire logic boost_hw_present, // strap: boost hardware fitted
    input wire logic thermal_headroom, // pin: headroom available
    input wire logic boost_criteria_met, // pin: internal criteria met
    input wire logic [`OBC_NLP-1:0] lp_active, // processor running
    input wire logic msr_rd, // register read strobe
    input wire logic msr_wr, // register write strobe
    input wire logic [`OBC_LPW-1:0] msr_lp, // issuing processor
    input wire logic [31:0] msr_addr, // register address
    input wire logic [63:0] msr_wdata, // write data
    output logic msr_ack, // access done pulse
    output logic msr_fault, // access refused or unmapped
    output obc_word_type msr_rdata, // read data
    input wire logic cq_req, // capability query strobe
    input wire logic [31:0] cq_leaf, // query leaf
    output logic cq_valid, // query answer pulse
    output logic [31:0] cq_eax, // first result word
    output logic [31:0] cq_ecx, // third result word
    output logic [`OBC_NLP-1:0] boost_active, // boost engaged per lp
    output logic [`OBC_BIAS_W-1:0] pkg_bias_hint, // resolved hint
    output logic boost_disabled // package disable bit
);
    logic [1:0] pres_s;
    logic [1:0] head_s;
    logic [1:0] crit_s;
    obc_init_type init_st;
    obc_init_type next_init_st;
    logic hw_present;
    logic next_hw_present;
    logic next_boost_disabled;
    logic run;
    obc_word_type ctl [`OBC_NLP];
    obc_word_type next_ctl [`OBC_NLP];
    obc_word_type aper [`OBC_NLP];
    obc_word_type next_aper [`OBC_NLP];
    obc_word_type mper [`OBC_NLP];
    obc_word_type next_mper [`OBC_NLP];
    logic [`OBC_BIAS_W-1:0] bias [`OBC_NLP];
    logic [`OBC_BIAS_W-1:0] next_bias [`OBC_NLP];
    logic [`OBC_NLP-1:0] next_boost_active;
    logic [`OBC_BIAS_W-1:0] next_pkg_bias_hint;
    logic next_msr_ack;
    logic next_msr_fault;
    obc_word_type next_msr_rdata;
    logic next_cq_valid;
    logic [31:0] next_cq_eax;
    logic [31:0] next_cq_ecx;

    // pins from outside pass two flops; logic reads only the second
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pres_s <= 2'h0;
            head_s <= 2'h0;
            crit_s <= 2'h0;
        end else begin
            pres_s <= {pres_s[0], boost_hw_present};
            head_s <= {head_s[0], thermal_headroom};
            crit_s <= {crit_s[0], boost_criteria_met};
        end
    end

    assign run = (init_st == OBC_RUN);

    // strap is caught after release, once the synchroniser has filled
    always_comb begin
        next_init_st = init_st;
        next_hw_present = hw_present;
        next_boost_disabled = boost_disabled;
        case (init_st)
            OBC_W0: next_init_st = OBC_W1;
            OBC_W1: next_init_st = OBC_W2;
            OBC_W2: begin
                next_init_st = OBC_RUN;
                next_hw_present = pres_s[1];
                next_boost_disabled = pres_s[1];
            end
            OBC_RUN: begin
                // any processor writes the one shared bit
                if (msr_wr && msr_addr == `OBC_ADDR_MISC) begin
                    next_boost_disabled =
                        msr_wdata[`OBC_MISC_DIS_BIT];
                end
            end
            default: next_init_st = OBC_W0;
        endcase
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            init_st <= OBC_W0;
            hw_present <= 1'b0;
            boost_disabled <= 1'b0;
        end else begin
            init_st <= next_init_st;
            hw_present <= next_hw_present;
            boost_disabled <= next_boost_disabled;
        end
    end

    // every check below runs on the core clock, quiet during reset
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    // per-processor state: control word, bias, feedback counters
    for (genvar g = 0; g < `OBC_NLP; g++) begin : g_lp
        logic wr_g;
        logic ovf_g;
        obc_word_type step_g;
        assign wr_g = run && msr_wr && (msr_lp == (`OBC_LPW)'(g));
        assign step_g = boost_active[g] ? `OBC_STEP_BOOST
                                        : `OBC_STEP_BASE;
        // both counters clear together when either would wrap
        assign ovf_g = (aper[g] > (`OBC_CNT_MAX - step_g)) ||
                       (mper[g] == `OBC_CNT_MAX);
        always_comb begin
            next_ctl[g] = ctl[g];
            next_bias[g] = bias[g];
            next_aper[g] = aper[g];
            next_mper[g] = mper[g];
            // whole word stored; software keeps the other bits
            if (wr_g && msr_addr == `OBC_ADDR_CTL) begin
                next_ctl[g] = msr_wdata;
            end
            if (wr_g && msr_addr == `OBC_ADDR_BIAS) begin
                next_bias[g] = msr_wdata[`OBC_BIAS_W-1:0];
            end
            // counters run only while the processor is active
            if (lp_active[g]) begin
                if (ovf_g) begin
                    next_aper[g] = 64'h0000000000000000;
                    next_mper[g] = 64'h0000000000000000;
                end else begin
                    next_aper[g] = aper[g] + step_g;
                    next_mper[g] = mper[g] + `OBC_STEP_BASE;
                end
            end
            // a write wins over the count in the same cycle
            if (wr_g && msr_addr == `OBC_ADDR_APERF) begin
                next_aper[g] = msr_wdata;
            end
            if (wr_g && msr_addr == `OBC_ADDR_MPERF) begin
                next_mper[g] = msr_wdata;
            end
            // entry is opportunistic, never promised
            next_boost_active[g] = run && hw_present && !boost_disabled &&
                !ctl[g][`OBC_CTL_DIS_BIT] && head_s[1] && crit_s[1];
        end
        a_lp_isolate: assert property (
            (msr_wr && msr_lp != (`OBC_LPW)'(g) &&
             msr_addr == `OBC_ADDR_CTL) |=> $stable(ctl[g]))
            else $error("control word of another processor changed");
        a_disengage_gate: assert property (
            (ctl[g][`OBC_CTL_DIS_BIT] || boost_disabled) |=>
            !boost_active[g])
            else $error("boost engaged while disabled or disengaged");
        a_ratio_above: assert property (
            (boost_active[g] && lp_active[g] && !ovf_g && !wr_g) |=>
            ((aper[g] - $past(aper[g])) > (mper[g] - $past(mper[g]))))
            else $error("actual counter not ahead while boosted");
        a_pkg_most_perf: assert property (
            run |=> (pkg_bias_hint <= $past(bias[g])))
            else $error("package hint less performant than a processor");
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < `OBC_NLP; i++) begin
                ctl[i] <= 64'h0000000000000000;
                bias[i] <= `OBC_BIAS_RST;
                aper[i] <= 64'h0000000000000000;
                mper[i] <= 64'h0000000000000000;
            end
        end else begin
            for (int i = 0; i < `OBC_NLP; i++) begin
                ctl[i] <= next_ctl[i];
                bias[i] <= next_bias[i];
                aper[i] <= next_aper[i];
                mper[i] <= next_mper[i];
            end
        end
    end

    // lowest value is most performance oriented; the hint only guides
    // the heuristics, its effect is left to the power manager
    always_comb begin
        next_pkg_bias_hint = bias[0];
        for (int i = 1; i < `OBC_NLP; i++) begin
            if (bias[i] < next_pkg_bias_hint) begin
                next_pkg_bias_hint = bias[i];
            end
        end
    end

    // register read and answer; refused until the strap is caught
    always_comb begin
        next_msr_ack = msr_rd || msr_wr;
        next_msr_fault = (msr_rd || msr_wr) && !run;
        next_msr_rdata = 64'h0000000000000000;
        case (msr_addr)
            `OBC_ADDR_MISC:
                next_msr_rdata[`OBC_MISC_DIS_BIT] = boost_disabled;
            `OBC_ADDR_STAT: // current point only, disengage hidden
                next_msr_rdata[`OBC_CTL_OP_W-1:0] =
                    ctl[msr_lp][`OBC_CTL_OP_W-1:0];
            `OBC_ADDR_CTL: next_msr_rdata = ctl[msr_lp];
            `OBC_ADDR_BIAS:
                next_msr_rdata[`OBC_BIAS_W-1:0] = bias[msr_lp];
            `OBC_ADDR_APERF: next_msr_rdata = aper[msr_lp];
            `OBC_ADDR_MPERF: next_msr_rdata = mper[msr_lp];
            default: next_msr_fault = msr_rd || msr_wr;
        endcase
        if (!msr_rd || !run) begin
            next_msr_rdata = 64'h0000000000000000;
        end
    end

    // capability query answers one cycle later
    always_comb begin
        next_cq_valid = cq_req;
        next_cq_eax = 32'h00000000;
        next_cq_ecx = 32'h00000000;
        if (cq_req && cq_leaf == `OBC_LEAF_PM) begin
            next_cq_eax[`OBC_EAX_BOOST_BIT] =
                hw_present && !boost_disabled && run;
            next_cq_ecx[`OBC_ECX_FEEDBACK_BIT] = 1'b1;
            next_cq_ecx[`OBC_ECX_BIAS_BIT] = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            boost_active <= '0;
            pkg_bias_hint <= `OBC_BIAS_RST;
            msr_ack <= 1'b0;
            msr_fault <= 1'b0;
            msr_rdata <= 64'h0000000000000000;
            cq_valid <= 1'b0;
            cq_eax <= 32'h00000000;
            cq_ecx <= 32'h00000000;
        end else begin
            boost_active <= next_boost_active;
            pkg_bias_hint <= next_pkg_bias_hint;
            msr_ack <= next_msr_ack;
            msr_fault <= next_msr_fault;
            msr_rdata <= next_msr_rdata;
            cq_valid <= next_cq_valid;
            cq_eax <= next_cq_eax;
            cq_ecx <= next_cq_ecx;
        end
    end

    sequence s_cq_leaf6;
        cq_req && cq_leaf == `OBC_LEAF_PM;
    endsequence
    sequence s_bias_read;
        msr_rd && !msr_wr && run && msr_addr == `OBC_ADDR_BIAS;
    endsequence

    a_reset_support: assert property (
        (init_st == OBC_W2) |=> (boost_disabled == $past(pres_s[1])))
        else $error("disable bit reset value does not report support");
    a_cq_boost_bit: assert property (
        s_cq_leaf6 ##0 boost_disabled |=> cq_valid && !cq_eax[1])
        else $error("query reports boost while disabled");
    a_cq_bias_bit: assert property (
        s_cq_leaf6 |=> cq_valid && cq_ecx[3])
        else $error("query omits bias register");
    a_status_hidden: assert property (
        (msr_rd && msr_addr == `OBC_ADDR_STAT) |=> !msr_rdata[32])
        else $error("status shows disengage bit");
    a_bias_upper: assert property (
        s_bias_read |=> msr_ack && msr_rdata[63:4] == 60'h0)
        else $error("bias upper bits not zero");
    a_disable_write: assert property (
        (run && msr_wr && msr_addr == `OBC_ADDR_MISC) |=>
        (boost_disabled == $past(msr_wdata[`OBC_MISC_DIS_BIT])) ##1
        (!$past(boost_disabled) || !(|boost_active)))
        else $error("disable write not taken");
    a_bias_reset: assert property (
        !run |-> (pkg_bias_hint == 4'h0) && (bias[0] == 4'h0))
        else $error("bias not at highest performance before run");
endmodule // obc_top

// >>> obc_params.svh
// constants for the opportunistic boost control block
// assumes one package with a fixed count of logical processors
`ifndef OBC_PARAMS_SVH
`define OBC_PARAMS_SVH
`define OBC_NLP 4
`define OBC_LPW 2
`define OBC_ADDR_MISC 32'h000001A0
`define OBC_ADDR_STAT 32'h00000198
`define OBC_ADDR_CTL 32'h00000199
`define OBC_ADDR_BIAS 32'h000001B0
`define OBC_ADDR_MPERF 32'h000000E7
`define OBC_ADDR_APERF 32'h000000E8
`define OBC_LEAF_PM 32'h00000006
`define OBC_MISC_DIS_BIT 38
`define OBC_CTL_DIS_BIT 32
`define OBC_CTL_OP_W 16
`define OBC_BIAS_W 4
`define OBC_BIAS_RST 4'h0
`define OBC_EAX_BOOST_BIT 1
`define OBC_ECX_FEEDBACK_BIT 0
`define OBC_ECX_BIAS_BIT 3
`define OBC_CNT_MAX 64'hFFFFFFFFFFFFFFFF
`define OBC_STEP_BOOST 64'h0000000000000002
`define OBC_STEP_BASE 64'h0000000000000001
`endif

// >>> obc_pkg.sv
// types for the opportunistic boost control block
// assumes obc_params.svh supplies the numeric constants
package obc_pkg;
    typedef enum logic [3:0] {
        OBC_W0 = 4'h1,
        OBC_W1 = 4'h2,
        OBC_W2 = 4'h4,
        OBC_RUN = 4'h8
    } obc_init_type;
    typedef logic [63:0] obc_word_type;
endpackage

// >>> tb.sv
// self-checking bench for the boost control register block
// assumes obc_top answers register and query strobes one cycle later
`timescale 1ns/1ps
`include "obc_params.svh"
module tb import obc_pkg::*;;
    logic clk_sys, resetn, hw, headroom, criteria, msr_rd, msr_wr, cq_req;
    logic [3:0] lp_active;
    logic [1:0] msr_lp;
    logic [31:0] msr_addr, cq_leaf, cq_eax, cq_ecx;
    logic [63:0] msr_wdata, last_rd, a, bv[4], wd0, wd1;
    obc_word_type msr_rdata;
    logic msr_ack, msr_fault, cq_valid, boost_disabled;
    logic [3:0] boost_active, pkg_bias_hint, bmin;
    logic [64:0] exp_q[$];
    logic [63:0] msk_q[$], cq_q[$];
    integer seed = 32;
    int mismatches = 0;
    int check_count = 0;
    localparam logic [63:0] ALL = 64'hFFFFFFFFFFFFFFFF;

    obc_top dut (.clk_sys(clk_sys), .resetn(resetn), .boost_hw_present(hw),
        .thermal_headroom(headroom), .boost_criteria_met(criteria),
        .lp_active(lp_active), .msr_rd(msr_rd), .msr_wr(msr_wr),
        .msr_lp(msr_lp), .msr_addr(msr_addr), .msr_wdata(msr_wdata),
        .msr_ack(msr_ack), .msr_fault(msr_fault), .msr_rdata(msr_rdata),
        .cq_req(cq_req), .cq_leaf(cq_leaf), .cq_valid(cq_valid),
        .cq_eax(cq_eax), .cq_ecx(cq_ecx), .boost_active(boost_active),
        .pkg_bias_hint(pkg_bias_hint), .boost_disabled(boost_disabled));

    // 50 MHz core clock
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    task automatic cmp(input logic [64:0] got, input logic [64:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // one register access; the note is queued before the strobe goes out
    task automatic acc(input logic wr, input logic [1:0] lp,
        input logic [31:0] ad, input logic [63:0] wd, input logic f,
        input logic [63:0] ed, input logic [63:0] m);
        exp_q.push_back({f, ed & m});
        msk_q.push_back(m);
        msr_wr <= wr;
        msr_rd <= !wr;
        msr_lp <= lp;
        msr_addr <= ad;
        msr_wdata <= wd;
        @(posedge clk_sys);
        msr_wr <= 1'b0;
        msr_rd <= 1'b0;
        @(posedge clk_sys);
        @(posedge clk_sys); // lets the watcher capture last_rd first
    endtask

    task automatic qry(input logic [31:0] leaf, input logic [63:0] e);
        cq_q.push_back(e);
        cq_req <= 1'b1;
        cq_leaf <= leaf;
        @(posedge clk_sys);
        cq_req <= 1'b0;
        @(posedge clk_sys);
    endtask

    // watcher: every answer pulse consumes the oldest note
    always @(posedge clk_sys) begin
        if (msr_ack === 1'b1) begin
            if (exp_q.size() == 0) begin
                cmp(65'h1, 65'h0);
            end else begin
                cmp({msr_fault, msr_rdata & msk_q.pop_front()},
                    exp_q.pop_front());
            end
            last_rd = msr_rdata;
        end
        if (cq_valid === 1'b1) begin
            if (cq_q.size() == 0) begin
                cmp(65'h1, 65'h0);
            end else begin
                cmp({1'b0, cq_eax, cq_ecx}, {1'b0, cq_q.pop_front()});
            end
        end
    end

    // watchdog sized well above the sequence length
    initial begin
        repeat (20000) @(posedge clk_sys);
        mismatches++;
        wrap_up();
    end

    // main sequence
    initial begin
        {resetn, msr_rd, msr_wr, cq_req} = 4'h0;
        {hw, headroom, criteria} = 3'b111;
        lp_active = 4'hF;
        msr_lp = 2'h0;
        msr_addr = 32'h0;
        cq_leaf = 32'h0;
        msr_wdata = 64'h0;
        repeat (20) @(posedge clk_sys);
        resetn <= 1'b1;
        acc(0, 0, `OBC_ADDR_MISC, 0, 1, 0, ALL); // too early: refused
        repeat (2) @(posedge clk_sys);
        acc(0, 3, `OBC_ADDR_MISC, 0, 0, 64'h0000004000000000, ALL);
        cmp({64'h0, boost_disabled}, 65'h1);
        qry(`OBC_LEAF_PM, {32'h0, 32'h9});
        qry(32'h0, 64'h0);
        acc(1, 2, `OBC_ADDR_MISC, 0, 0, 0, ALL);
        acc(0, 0, `OBC_ADDR_MISC, 0, 0, 0, ALL);
        qry(`OBC_LEAF_PM, {32'h2, 32'h9});
        acc(0, 1, 32'h00000100, 0, 1, 0, ALL); // unmapped address
        $display("test init and query done");
        bmin = 4'hF;
        for (int i = 0; i < 4; i++) begin
            acc(0, i, `OBC_ADDR_BIAS, 0, 0, 0, ALL);
            bv[i] = {$random(seed), $random(seed)};
            if (i == 0) bv[i][3:0] = 4'hF;
            if (bv[i][3:0] < bmin) bmin = bv[i][3:0];
            acc(1, i, `OBC_ADDR_BIAS, bv[i], 0, 0, ALL);
        end
        for (int i = 0; i < 4; i++) begin
            acc(0, i, `OBC_ADDR_BIAS, 0, 0, {60'h0, bv[i][3:0]}, ALL);
        end
        cmp({61'h0, pkg_bias_hint}, {61'h0, bmin});
        $display("test bias done");
        wd1 = {$random(seed), $random(seed)};
        wd1[32] = 1'b0;
        wd0 = {$random(seed), $random(seed)};
        wd0[32] = 1'b1;
        acc(1, 1, `OBC_ADDR_CTL, wd1, 0, 0, ALL);
        acc(1, 0, `OBC_ADDR_CTL, wd0, 0, 0, ALL);
        acc(0, 1, `OBC_ADDR_CTL, 0, 0, wd1, ALL);
        acc(0, 0, `OBC_ADDR_STAT, 0, 0, {48'h0, wd0[15:0]},
            64'h000000010000FFFF);
        repeat (6) @(posedge clk_sys);
        cmp({63'h0, boost_active[1:0]}, {63'h0, 2'b10});
        // re-engage by read-modify-write, other bits kept as read
        acc(0, 0, `OBC_ADDR_CTL, 0, 0, wd0, ALL);
        wd0 = last_rd;
        wd0[32] = 1'b0;
        acc(1, 0, `OBC_ADDR_CTL, wd0, 0, 0, ALL);
        repeat (6) @(posedge clk_sys);
        cmp({63'h0, boost_active[1:0]}, {63'h0, 2'b11});
        headroom <= 1'b0;
        repeat (6) @(posedge clk_sys);
        cmp({63'h0, boost_active[1:0]}, 65'h0);
        headroom <= 1'b1;
        criteria <= 1'b0;
        repeat (6) @(posedge clk_sys);
        cmp({61'h0, boost_active}, 65'h0);
        criteria <= 1'b1;
        acc(1, 3, `OBC_ADDR_MISC, 64'h0000004000000000, 0, 0, ALL);
        repeat (6) @(posedge clk_sys);
        cmp({60'h0, boost_disabled, boost_active}, 65'h10);
        acc(1, 3, `OBC_ADDR_MISC, 0, 0, 0, ALL);
        repeat (6) @(posedge clk_sys);
        $display("test boost control done");
        // actual counter read first, so only a faster step can lead
        acc(1, 1, `OBC_ADDR_MPERF, 0, 0, 0, ALL);
        acc(1, 1, `OBC_ADDR_APERF, 0, 0, 0, ALL);
        repeat (40) @(posedge clk_sys);
        acc(0, 1, `OBC_ADDR_APERF, 0, 0, 0, 64'h0);
        a = last_rd;
        acc(0, 1, `OBC_ADDR_MPERF, 0, 0, 0, 64'h0);
        cmp({64'h0, a > last_rd}, 65'h1);
        // an idle processor holds its counters still
        lp_active[2] <= 1'b0;
        acc(1, 2, `OBC_ADDR_MPERF, 0, 0, 0, ALL);
        repeat (10) @(posedge clk_sys);
        acc(0, 2, `OBC_ADDR_MPERF, 0, 0, 0, ALL);
        $display("test counters done");
        // second reset without boost hardware: support bit comes up 0
        hw <= 1'b0;
        resetn <= 1'b0;
        repeat (4) @(posedge clk_sys);
        resetn <= 1'b1;
        repeat (3) @(posedge clk_sys);
        acc(0, 1, `OBC_ADDR_MISC, 0, 0, 0, ALL);
        acc(0, 2, `OBC_ADDR_BIAS, 0, 0, 0, ALL);
        qry(`OBC_LEAF_PM, {32'h0, 32'h9});
        cmp({61'h0, boost_active}, 65'h0);
        cmp({64'h0, boost_disabled}, 65'h0);
        $display("test reset without hardware done");
        wrap_up();
    end
endmodule // tb
